//--- hdl/cfr_readout_seq.sv
// Operation
// R1 - the first 11 pixels of each line are dummies, never dark reference
// R2 - the next 4 pixels are test pixels, never dark reference
// R3 - the last three pixels of each line are test pixels, never dark reference
// R4 - 20 leading shielded pixels per line may serve as dark reference
// R5 - 20 leading and 9 trailing shielded lines may serve as dark reference
// R6 - one buffer row and column border the image and are not active
// R7 - both vertical phases stay low during integration
// R8 - line enters horizontal register on vertical b fall with horizontal a high
// R9 - horizontal phases toggle alternately and always complementary
// R10 - after each video sample the charge clear gate is pulsed
// R11 - brighter pixel means video level more negative than reset level
// R12 - all pins of one phase are driven together with identical timing
// R13 - each vertical transfer pulse lasts at least 20 microseconds
// R14 - integrate, then per line one vertical transfer and full horizontal shift
`include "cfr_readout_map.svh"

module cfr_readout_seq
  import cfr_pkg::*;
#(
  parameter int VPINS = 4,
  parameter int HPINS = 1,
  parameter int COLS = `CFR_COLS_TOTAL,
  parameter int ROWS = `CFR_ROWS_TOTAL,
  parameter int VERT_PULSE_CYC = `CFR_VERT_PULSE_CYC,
  parameter int QUARTER_CYC = `CFR_QUARTER_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [31:0] integ_len_i,
  output logic [VPINS-1:0] vert_phase_a_o,
  output logic [VPINS-1:0] vert_phase_b_o,
  output logic [HPINS-1:0] horiz_phase_a_o,
  output logic [HPINS-1:0] horiz_phase_b_o,
  output logic charge_clear_gate_o,
  output logic samp_reset_o,
  output logic samp_video_o,
  output cfr_pkg::cfr_pix_class_t pix_class_o,
  output logic dark_ref_o,
  output logic [15:0] pix_col_o,
  output logic [15:0] pix_row_o,
  output logic busy_o,
  output logic frame_done_o
);

  import cfr_pkg::*;

  // --------------------------------------------------------------------------
  // region boundaries
  // --------------------------------------------------------------------------
  localparam logic [15:0] COL_TEST_LO = 16'(`CFR_COL_DUMMY);
  localparam logic [15:0] COL_DARK_LO = 16'(`CFR_COL_DUMMY + `CFR_COL_TEST_LEAD);
  localparam logic [15:0] COL_BUF_LO = 16'(`CFR_COL_DUMMY + `CFR_COL_TEST_LEAD + `CFR_COL_DARK);
  localparam logic [15:0] COL_ACT_LO = COL_BUF_LO + 16'(`CFR_COL_BUFFER);
  localparam logic [15:0] COL_ACT_HI = COL_ACT_LO + 16'(`CFR_COL_ACTIVE);
  localparam logic [15:0] COL_TTEST_LO = 16'(COLS - `CFR_COL_TEST_TAIL);
  localparam logic [15:0] ROW_BUF_LO = 16'(`CFR_ROW_DARK_LEAD);
  localparam logic [15:0] ROW_ACT_LO = ROW_BUF_LO + 16'(`CFR_ROW_BUFFER);
  localparam logic [15:0] ROW_ACT_HI = ROW_ACT_LO + 16'(`CFR_ROW_ACTIVE);
  localparam logic [15:0] ROW_TDARK_LO = 16'(ROWS - `CFR_ROW_DARK_TAIL);
  localparam logic [15:0] COL_LAST = 16'(COLS - 1);
  localparam logic [15:0] ROW_LAST = 16'(ROWS - 1);
  localparam logic [31:0] VW_LAST = 32'(VERT_PULSE_CYC - 1);

  cfr_seq_state_t state_reg;
  cfr_seq_state_t state_next;
  logic tick;

  // --------------------------------------------------------------------------
  // quarter-pixel enable, runs only in the shift and tail states
  // --------------------------------------------------------------------------
  cfr_tick_div #(
    .DIV(QUARTER_CYC)
  ) u_quarter_div (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(state_reg.st == CFR_SHIFT || state_reg.st == CFR_TAIL),
    .tick_o(tick)
  );

  // --------------------------------------------------------------------------
  // pixel classification at the sampled position
  // --------------------------------------------------------------------------
  function automatic cfr_pix_class_t classify(input logic [15:0] c, input logic [15:0] r);
    cfr_pix_class_t k;
    k = CFR_PIX_BUFFER;
    if (c < COL_TEST_LO) begin
      k = CFR_PIX_DUMMY; // R1
    end else if (c < COL_DARK_LO || c >= COL_TTEST_LO) begin
      k = CFR_PIX_TEST; // R2 R3
    end else if (c < COL_BUF_LO || r < ROW_BUF_LO || r >= ROW_TDARK_LO) begin
      k = CFR_PIX_DARK; // R4 R5
    end else if (c >= COL_ACT_LO && c < COL_ACT_HI && r >= ROW_ACT_LO && r < ROW_ACT_HI) begin
      k = CFR_PIX_ACTIVE;
    end else begin
      k = CFR_PIX_BUFFER; // R6
    end
    return k;
  endfunction

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  // pixel quarters: 0 clear gate high, 1 reset level sample, 2 charge onto
  // the sense node, 3 video sample; clearing leads the next pixel so it
  // always follows the previous video sample
  always_comb begin
    state_next = state_reg;
    state_next.samp_reset = 1'b0;
    state_next.samp_video = 1'b0;
    state_next.frame_done = 1'b0;
    case (state_reg.st)
      CFR_IDLE: begin
        state_next.vert_a = 1'b0;
        state_next.vert_b = 1'b0;
        state_next.horiz_a = 1'b1;
        state_next.horiz_b = 1'b0;
        state_next.clear_gate = 1'b0;
        if (start_i) begin
          state_next.st = CFR_INTEG; // R14
          state_next.cnt = '0;
          state_next.row = '0;
        end
      end
      CFR_INTEG: begin
        // vertical phases frozen low while charge collects
        state_next.vert_a = 1'b0; // R7
        state_next.vert_b = 1'b0; // R7
        if (state_reg.cnt + 32'h0000_0001 >= integ_len_i) begin
          state_next.st = CFR_VXA; // R14
          // phase a rises with the state change so it stands the full count
          state_next.vert_a = 1'b1; // R13
          state_next.cnt = '0;
        end else begin
          state_next.cnt = state_reg.cnt + 32'h0000_0001;
        end
      end
      CFR_VXA: begin
        state_next.vert_a = 1'b1;
        if (state_reg.cnt == VW_LAST) begin
          state_next.st = CFR_VXB; // R13
          state_next.cnt = '0;
          state_next.vert_a = 1'b0;
          state_next.vert_b = 1'b1;
          state_next.horiz_a = 1'b1; // R8
          state_next.horiz_b = 1'b0;
        end else begin
          state_next.cnt = state_reg.cnt + 32'h0000_0001;
        end
      end
      CFR_VXB: begin
        if (state_reg.cnt == VW_LAST) begin
          // falling edge of vertical b with horizontal a still high
          state_next.vert_b = 1'b0; // R8 R13
          state_next.st = CFR_SHIFT; // R14
          state_next.cnt = '0;
          state_next.col = '0;
          state_next.quarter = 2'b00;
        end else begin
          state_next.cnt = state_reg.cnt + 32'h0000_0001;
        end
      end
      CFR_SHIFT: begin
        if (tick) begin
          state_next.quarter = state_reg.quarter + 2'b01;
          case (state_reg.quarter)
            2'b00: begin
              state_next.clear_gate = 1'b1; // R10
              state_next.horiz_a = 1'b1; // R9
              state_next.horiz_b = 1'b0; // R9
            end
            2'b01: begin
              state_next.clear_gate = 1'b0;
              state_next.samp_reset = 1'b1; // R11
            end
            2'b10: begin
              state_next.horiz_a = 1'b0; // R9
              state_next.horiz_b = 1'b1; // R9
            end
            default: begin
              // tag travels with the strobe so the sampler never mislabels
              state_next.samp_video = 1'b1; // R11
              state_next.pix_class = classify(state_reg.col, state_reg.row);
              state_next.dark_ref = (classify(state_reg.col, state_reg.row) == CFR_PIX_DARK); // R1 R2 R3 R4 R5
              state_next.pix_col = state_reg.col;
              state_next.pix_row = state_reg.row;
              if (state_reg.col != COL_LAST) begin
                state_next.col = state_reg.col + 16'h0001;
              end else if (state_reg.row != ROW_LAST) begin
                state_next.row = state_reg.row + 16'h0001;
                state_next.st = CFR_VXA; // R14
                state_next.vert_a = 1'b1; // R13
                state_next.cnt = '0;
              end else begin
                state_next.st = CFR_TAIL;
              end
            end
          endcase
        end
      end
      CFR_TAIL: begin
        // last pixel still needs its clear pulse before going idle
        if (tick) begin
          state_next.quarter = state_reg.quarter + 2'b01;
          if (state_reg.quarter == 2'b00) begin
            state_next.clear_gate = 1'b1; // R10
            state_next.horiz_a = 1'b1; // R9
            state_next.horiz_b = 1'b0; // R9
          end else begin
            state_next.clear_gate = 1'b0;
            state_next.st = CFR_IDLE;
            state_next.frame_done = 1'b1;
          end
        end
      end
      default: begin
        state_next.st = CFR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
      state_reg.horiz_a <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // pin fan-out
  // --------------------------------------------------------------------------
  // each pin of a phase copies the same flop, so no skew is added here
  generate
    for (genvar i = 0; i < VPINS; i++) begin : g_vpin
      assign vert_phase_a_o[i] = state_reg.vert_a; // R12
      assign vert_phase_b_o[i] = state_reg.vert_b; // R12
    end
    for (genvar j = 0; j < HPINS; j++) begin : g_hpin
      assign horiz_phase_a_o[j] = state_reg.horiz_a; // R12
      assign horiz_phase_b_o[j] = state_reg.horiz_b; // R12
    end
  endgenerate

  assign charge_clear_gate_o = state_reg.clear_gate;
  assign samp_reset_o = state_reg.samp_reset;
  assign samp_video_o = state_reg.samp_video;
  assign pix_class_o = state_reg.pix_class;
  assign dark_ref_o = state_reg.dark_ref;
  assign pix_col_o = state_reg.pix_col;
  assign pix_row_o = state_reg.pix_row;
  assign busy_o = (state_reg.st != CFR_IDLE);
  assign frame_done_o = state_reg.frame_done;

endmodule // cfr_readout_seq

//--- hdl/cfr_readout_map.svh
`ifndef CFR_READOUT_MAP_SVH
`define CFR_READOUT_MAP_SVH

// ----------------------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------------------
`define CFR_COLS_TOTAL 4145
`define CFR_ROWS_TOTAL 4128
`define CFR_COL_DUMMY 11
`define CFR_COL_TEST_LEAD 4
`define CFR_COL_DARK 20
`define CFR_COL_BUFFER 1
`define CFR_COL_ACTIVE 4096
`define CFR_COL_TEST_TAIL 3
`define CFR_ROW_DARK_LEAD 20
`define CFR_ROW_BUFFER 1
`define CFR_ROW_ACTIVE 4096
`define CFR_ROW_DARK_TAIL 9

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CFR_CLK_PERIOD_PS 4000
`define CFR_VERT_PULSE_US 20
`define CFR_VERT_PULSE_CYC ((`CFR_VERT_PULSE_US * 1000000 + `CFR_CLK_PERIOD_PS - 1) / `CFR_CLK_PERIOD_PS)
`define CFR_HCLK_PERIOD_NS 250
`define CFR_QUARTER_CYC ((`CFR_HCLK_PERIOD_NS * 1000 + 4 * `CFR_CLK_PERIOD_PS - 1) / (4 * `CFR_CLK_PERIOD_PS))

`endif

//--- hdl/cfr_pkg.sv
package cfr_pkg;

  // --------------------------------------------------------------------------
  // sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CFR_IDLE  = 3'b000,
    CFR_INTEG = 3'b001,
    CFR_VXA   = 3'b010,
    CFR_VXB   = 3'b011,
    CFR_SHIFT = 3'b100,
    CFR_TAIL  = 3'b101
  } cfr_state_t;

  // --------------------------------------------------------------------------
  // pixel classes tagged on each video sample
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CFR_PIX_DUMMY  = 3'b000,
    CFR_PIX_TEST   = 3'b001,
    CFR_PIX_DARK   = 3'b010,
    CFR_PIX_BUFFER = 3'b011,
    CFR_PIX_ACTIVE = 3'b100
  } cfr_pix_class_t;

  // --------------------------------------------------------------------------
  // whole sequencer state
  // --------------------------------------------------------------------------
  typedef struct packed {
    cfr_state_t st;
    logic [31:0] cnt;
    logic [15:0] col;
    logic [15:0] row;
    logic [1:0] quarter;
    logic vert_a;
    logic vert_b;
    logic horiz_a;
    logic horiz_b;
    logic clear_gate;
    logic samp_reset;
    logic samp_video;
    logic dark_ref;
    cfr_pix_class_t pix_class;
    logic [15:0] pix_col;
    logic [15:0] pix_row;
    logic frame_done;
  } cfr_seq_state_t;

endpackage

//--- hdl/cfr_tick_div.sv
`include "cfr_readout_map.svh"

// one-cycle enable pulse every DIV clocks while run_i is high
module cfr_tick_div #(
  parameter int DIV = `CFR_QUARTER_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  output logic tick_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } cfr_div_state_t;

  cfr_div_state_t state_reg;
  cfr_div_state_t state_next;

  // --------------------------------------------------------------------------
  // divider
  // --------------------------------------------------------------------------
  // counter restarts when stopped so every run begins with a full period
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (!run_i) begin
      state_next.cnt = '0;
    end else if (state_reg.cnt == 16'(DIV - 1)) begin
      state_next.cnt = '0;
      state_next.tick = 1'b1;
    end else begin
      state_next.cnt = state_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick_o = state_reg.tick;

endmodule // cfr_tick_div

//--- dv/cfr_readout_monitor.sv
module cfr_readout_monitor
  import cfr_pkg::*;
#(
  parameter int VPINS = 4,
  parameter int HPINS = 1,
  parameter int VERT_PULSE_CYC = 4,
  parameter int QUARTER_CYC = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [VPINS-1:0] vert_phase_a_o,
  input wire logic [VPINS-1:0] vert_phase_b_o,
  input wire logic [HPINS-1:0] horiz_phase_a_o,
  input wire logic [HPINS-1:0] horiz_phase_b_o,
  input wire logic charge_clear_gate_o,
  input wire logic samp_reset_o,
  input wire logic samp_video_o,
  input wire cfr_pkg::cfr_pix_class_t pix_class_o,
  input wire logic dark_ref_o,
  input wire logic busy_o,
  input wire logic frame_done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import cfr_pkg::*;
  localparam int CDS_GAP = 2 * QUARTER_CYC;
  logic [31:0] va_cnt_reg;
  logic [31:0] vb_cnt_reg;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------------------
  // pulse width counters, cleared on each low cycle so a fall sees the width
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      va_cnt_reg <= 32'h0;
      vb_cnt_reg <= 32'h0;
    end else begin
      va_cnt_reg <= vert_phase_a_o[0] ? va_cnt_reg + 32'h1 : 32'h0;
      vb_cnt_reg <= vert_phase_b_o[0] ? vb_cnt_reg + 32'h1 : 32'h0;
    end
  end
  // ----------------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------------
  property p_integ_idle; $rose(busy_o) |-> vert_phase_a_o == '0 && vert_phase_b_o == '0; endproperty
  property p_line_edge; $fell(vert_phase_b_o[0]) |-> horiz_phase_a_o[0]; endproperty
  property p_compl; horiz_phase_b_o == ~horiz_phase_a_o; endproperty
  property p_pins_same; (vert_phase_a_o == '0 || vert_phase_a_o == '1) && (vert_phase_b_o == '0 || vert_phase_b_o == '1);
  endproperty
  property p_va_width; $fell(vert_phase_a_o[0]) |-> va_cnt_reg == VERT_PULSE_CYC; endproperty
  property p_vb_width; $fell(vert_phase_b_o[0]) |-> vb_cnt_reg == VERT_PULSE_CYC; endproperty
  property p_no_overlap; !(vert_phase_a_o[0] && vert_phase_b_o[0]); endproperty
  property p_clear_after; samp_video_o |-> ##[1:40] charge_clear_gate_o; endproperty
  property p_cds_order; samp_reset_o |-> ##CDS_GAP samp_video_o; endproperty
  property p_dark_flag; samp_video_o |=> dark_ref_o == (pix_class_o == CFR_PIX_DARK); endproperty
  property p_done_idle; frame_done_o |-> !busy_o; endproperty
  a_integ_idle: assert property (p_integ_idle) else $error("vertical phase active at integration start");
  a_line_edge: assert property (p_line_edge) else $error("vertical b fell with horizontal a low");
  a_compl: assert property (p_compl) else $error("horizontal phases not complementary");
  a_pins_same: assert property (p_pins_same) else $error("phase pin copies differ");
  a_va_width: assert property (p_va_width) else $error("vertical a pulse width wrong");
  a_vb_width: assert property (p_vb_width) else $error("vertical b pulse width wrong");
  a_no_overlap: assert property (p_no_overlap) else $error("vertical phases overlap");
  a_clear_after: assert property (p_clear_after) else $error("no clear after video sample");
  a_cds_order: assert property (p_cds_order) else $error("video sample not after reset sample");
  a_dark_flag: assert property (p_dark_flag) else $error("dark flag disagrees with class");
  a_done_idle: assert property (p_done_idle) else $error("busy during frame done");
  c_done: cover property (frame_done_o);
  c_active: cover property (samp_video_o ##1 pix_class_o == CFR_PIX_ACTIVE);
  c_line: cover property ($fell(vert_phase_b_o[0]));
endmodule // cfr_readout_monitor

bind cfr_readout_seq cfr_readout_monitor #(.VPINS(VPINS), .HPINS(HPINS), .VERT_PULSE_CYC(VERT_PULSE_CYC),
  .QUARTER_CYC(QUARTER_CYC)) cfr_readout_monitor_i (.sys_clk_i, .rst_n_i, .vert_phase_a_o, .vert_phase_b_o,
  .horiz_phase_a_o, .horiz_phase_b_o, .charge_clear_gate_o, .samp_reset_o, .samp_video_o, .pix_class_o,
  .dark_ref_o, .busy_o, .frame_done_o);

//--- dv/cfr_ccd_model.sv
// behavioural sensor: counts line transfers, shows sense node level on the video pin
module cfr_ccd_model #(
  parameter int VPINS = 4
) (
  input wire logic [VPINS-1:0] vert_phase_b_i,
  input wire logic horiz_phase_b_i,
  input wire logic charge_clear_gate_i,
  output logic [15:0] line_cnt_o,
  output logic signed [15:0] video_out_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic vb_prev;
  initial line_cnt_o = 16'h0;
  initial video_out_o = 16'sh0;
  initial vb_prev = 1'b0;
  // only pin 0 is watched: copies of a phase are tied on the board; a true high to low
  // step is required so the unknown to low step at reset is not taken for a transfer
  always @(vert_phase_b_i[0]) begin
    if (vb_prev === 1'b1 && vert_phase_b_i[0] === 1'b0) begin
      line_cnt_o <= line_cnt_o + 16'h1;
    end
    vb_prev = vert_phase_b_i[0];
  end
  // charge dumped onto the sense node pulls the output below the reset level
  always @(posedge horiz_phase_b_i) begin
    video_out_o <= -16'sh64;
  end
  always @(posedge charge_clear_gate_i) begin
    video_out_o <= 16'sh0;
  end
endmodule // cfr_ccd_model

//--- dv/test_cfr_readout_seq.sv
module test_cfr_readout_seq;
  timeunit 1ns;
  timeprecision 100ps;
  import cfr_pkg::*;
  localparam int C = 40;
  localparam int R = 31;
  typedef struct {int c; int r; cfr_pix_class_t k;} cfr_row_t;
  cfr_row_t tbl [14] = '{'{0, 0, CFR_PIX_DUMMY}, '{10, 0, CFR_PIX_DUMMY}, '{11, 0, CFR_PIX_TEST},
    '{14, 0, CFR_PIX_TEST}, '{15, 0, CFR_PIX_DARK}, '{34, 0, CFR_PIX_DARK}, '{35, 20, CFR_PIX_BUFFER},
    '{36, 20, CFR_PIX_BUFFER}, '{35, 21, CFR_PIX_BUFFER}, '{36, 21, CFR_PIX_ACTIVE}, '{37, 21, CFR_PIX_TEST},
    '{39, 21, CFR_PIX_TEST}, '{36, 22, CFR_PIX_DARK}, '{0, 30, CFR_PIX_DUMMY}};
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start_i = 1'b0;
  logic [31:0] integ_len_i = 32'h5;
  logic [3:0] vert_phase_a_o, vert_phase_b_o;
  logic [0:0] horiz_phase_a_o, horiz_phase_b_o;
  logic charge_clear_gate_o, samp_reset_o, samp_video_o, dark_ref_o, busy_o, frame_done_o;
  cfr_pix_class_t pix_class_o;
  logic [15:0] pix_col_o, pix_row_o, line_cnt;
  logic signed [15:0] video_out;
  int n_errors = 0;
  int total_checks = 0;
  int n_video = 0;
  int n_done = 0;
  int i, j;
  cfr_readout_seq #(.COLS(C), .ROWS(R), .VERT_PULSE_CYC(4), .QUARTER_CYC(2)) cfr_readout_seq_i (.sys_clk_i,
    .rst_n_i, .start_i, .integ_len_i, .vert_phase_a_o, .vert_phase_b_o, .horiz_phase_a_o, .horiz_phase_b_o,
    .charge_clear_gate_o, .samp_reset_o, .samp_video_o, .pix_class_o, .dark_ref_o, .pix_col_o, .pix_row_o,
    .busy_o, .frame_done_o);
  cfr_ccd_model cfr_ccd_model_i (.vert_phase_b_i(vert_phase_b_o), .horiz_phase_b_i(horiz_phase_b_o[0]),
    .charge_clear_gate_i(charge_clear_gate_o), .line_cnt_o(line_cnt), .video_out_o(video_out));
  initial forever #2 sys_clk_i = ~sys_clk_i;
  // pulses counted mid-cycle, away from the edge that launches them
  always @(negedge sys_clk_i) begin
    if (samp_video_o === 1'b1) n_video++;
    if (frame_done_o === 1'b1) n_done++;
  end
  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task tick(int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task hang(int k, int lim);
    if (k >= lim) begin
      n_errors++;
      stop_test;
    end
  endtask
  task wait_done;
    for (j = 0; j < 12000 && frame_done_o !== 1'b1; j++) tick(1);
    hang(j, 12000);
  endtask
  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    tick(6);
    chk("idle_ha", horiz_phase_a_o, 32'h1);
    chk("idle_busy", busy_o, 32'h0);
    rst_n_i = 1'b1;
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
    tick(1);
    chk("busy", busy_o, 32'h1);
    start_i = 1'b1; // ignored while busy
    tick(1);
    start_i = 1'b0;
    // pixel classes in scan order, one frame
    for (i = 0; i < 14; i++) begin
      for (j = 0; j < 12000 && !(samp_video_o === 1'b1 && pix_col_o === 16'(tbl[i].c)
          && pix_row_o === 16'(tbl[i].r)); j++) tick(1);
      hang(j, 12000);
      chk("class", 32'(pix_class_o), 32'(tbl[i].k));
      chk("dark", dark_ref_o, 32'(tbl[i].k == CFR_PIX_DARK));
      chk("video", video_out[15], 32'h1);
    end
    integ_len_i = 32'h32;
    start_i = 1'b1; // held: taken back to back at frame end
    wait_done;
    chk("done_busy", busy_o, 32'h0);
    tick(1);
    chk("b2b_busy", busy_o, 32'h1);
    start_i = 1'b0;
    chk("frames", 32'(n_done), 32'h1);
    chk("pixels", 32'(n_video), 32'(C * R));
    chk("lines", line_cnt, 32'(R));
    for (j = 0; j < 200 && vert_phase_a_o[0] !== 1'b1; j++) tick(1);
    hang(j, 200);
    chk("integ", 32'(j >= 50), 32'h1);
    tick(30);
    rst_n_i = 1'b0;
    tick(1);
    chk("rst_va", vert_phase_a_o | vert_phase_b_o, 32'h0);
    chk("rst_busy", busy_o, 32'h0);
    rst_n_i = 1'b1;
    tick(2);
    chk("rst_ha", horiz_phase_a_o, 32'h1);
    stop_test;
  end
endmodule // test_cfr_readout_seq
